// file: verilog/cbadc_regs.vh
// Constants for the charge-balance converter sequencer
`ifndef CBADC_REGS_VH
`define CBADC_REGS_VH
`define CBADC_XTAL_HZ 3276800
`define CBADC_BUS_DIV 5
`define CBADC_BUS_HZ 655360
`define CBADC_BAL_TIME_MS 100
`define CBADC_BAL_CYCLES (`CBADC_BUS_HZ * `CBADC_BAL_TIME_MS / 1000)
`define CBADC_SETTLE_DEF 16'h0100
`define CBADC_TAP_BIT 3
`define CBADC_PULSE_LONG 8'h0C
`define CBADC_PULSE_SHORT 8'h04
`define CBADC_MUX_SIG 2'h0
`define CBADC_MUX_ZERO 2'h1
`define CBADC_MUX_REF 2'h2
`define CBADC_MUX_OHMS 2'h3
`define CBADC_FN_DCV 3'h0
`define CBADC_FN_ACV 3'h1
`define CBADC_FN_OHM 3'h2
`define CBADC_FN_DCA 3'h3
`define CBADC_FN_ACA 3'h4
`define CBADC_RANGE_LOW 3'h0
`define CBADC_RANGE_2V 3'h1
`define CBADC_RANGE_TOP 3'h4
`define CBADC_CAL_DCV_BASE 5'h00
`define CBADC_CAL_ACV_BASE 5'h08
`define CBADC_CAL_OHM_BASE 5'h10
`define CBADC_CAL_WORDS 24
`define CBADC_DISP_CFG 4'h3
`define CBADC_DISP_STEPS 4
`endif

// file: verilog/cbadc_clock_divider.v
// Crystal divide-by-five and binary divider chain
`timescale 1ns/10ps
`default_nettype none
`include "cbadc_regs.vh"
module cbadc_clock_divider #(
	parameter DIV = `CBADC_BUS_DIV,
	parameter CHAIN = 8
) (
	// Clock and control
	input wire ref_clk,
	input wire reset,
	input wire clkEn,
	// Outputs
	output reg busTick,
	output reg [CHAIN-1:0] chain
);
	reg [2:0] preCnt_r;
	always @(posedge ref_clk) begin
		if (reset) begin
			preCnt_r <= 3'h0;
			busTick <= 1'b0;
			chain <= {CHAIN{1'b0}};
		end else if (clkEn) begin
			busTick <= 1'b0;
			if (preCnt_r == DIV[2:0] - 3'h1) begin
				preCnt_r <= 3'h0;
				busTick <= 1'b1;
				chain <= chain + {{(CHAIN-1){1'b0}}, 1'b1};
			end else begin
				preCnt_r <= preCnt_r + 3'h1;
			end
		end
	end
endmodule // cbadc_clock_divider
`default_nettype wire

// file: verilog/cbadc_sequencer.v
// Charge-balance and single-slope conversion sequencer
`timescale 1ns/10ps
`default_nettype none
`include "cbadc_regs.vh"
// How it works
// - Crystal clock divided by five gives bus tick feeding binary divider chain.
// - Mux select drives exactly one of signal, zero, reference, ohms reference.
// - Each cycle converts signal, zero and reference inputs in turn.
// - After settle delay, input enable goes high to start charge balance.
// - Divider tap rising edge starts feedback pulse; length from balance comparator.
// - Bus ticks while feedback pulse is high add to balance count.
// - Charge balance lasts 100 ms then single slope begins.
// - Single slope opens integrator switch, counts while slope comparator high.
// - Ohms function switches in the larger input offset.
// - AC preamp gain five on lowest AC range, unity otherwise.
// - Ohms uses four inputs; lowest ohms range flags tenfold sense scaling.
// - Calibration constants loaded at power-up, shared for 750 V AC and currents.
// - Bus address latched on address strobe rising edge, shown during data strobe.
// - Display controller configured for triplexed drive over four lines at power-up.
// - Low battery comparator assertion flags end of battery life.
module cbadc_sequencer #(
	parameter BAL_CYCLES = `CBADC_BAL_CYCLES,
	parameter CW = 24,
	parameter SW = 16,
	parameter CALW = 16
) (
	// Clock, reset, enable
	input wire ref_clk,
	input wire reset,
	input wire clkEn,
	// Control
	input wire start,
	input wire [2:0] funcSel,
	input wire [2:0] range,
	input wire [15:0] settleCycles,
	// Analog front end
	input wire balanceComparator,
	input wire slopeComparator,
	input wire lowBattery,
	output reg [1:0] muxSel,
	output reg inputEnable,
	output reg feedbackPulse,
	output reg integratorSwitch,
	output reg ohmsOffsetSwitch,
	output reg acPreampGain5,
	output reg ohmsSenseX10,
	output reg batteryLow,
	// Conversion results
	output reg [CW+SW-1:0] result,
	output reg [1:0] resultInput,
	output reg resultValid,
	output reg cycleDone,
	output reg [CALW-1:0] calConstant,
	output reg calReady,
	// Calibration store
	output reg [4:0] calAddr,
	input wire [CALW-1:0] calData,
	// Bus address latch
	input wire addrStrobe,
	input wire dataStrobe,
	input wire [12:0] busAddr,
	output reg [12:0] progAddr,
	// Display driver
	output reg [3:0] displayCtrl
);
	localparam S_IDLE = 3'd0;
	localparam S_SETTLE = 3'd1;
	localparam S_BAL = 3'd2;
	localparam S_SLOPE = 3'd3;
	localparam S_NEXT = 3'd4;
	localparam S_CAL = 3'd5;

	wire busTick;
	wire [7:0] chain;
	cbadc_clock_divider #(.DIV(`CBADC_BUS_DIV), .CHAIN(8)) divider (
		.ref_clk(ref_clk),
		.reset(reset),
		.clkEn(clkEn),
		.busTick(busTick),
		.chain(chain)
	);

	// Calibration slot per function and range
	function [4:0] calSlot;
		input [2:0] fn;
		input [2:0] rg;
		begin
			if (fn == `CBADC_FN_ACV && rg == `CBADC_RANGE_TOP)
				calSlot = `CBADC_CAL_ACV_BASE + {2'b00, `CBADC_RANGE_2V};
			else if (fn == `CBADC_FN_ACV)
				calSlot = `CBADC_CAL_ACV_BASE + {2'b00, rg};
			else if (fn == `CBADC_FN_ACA)
				calSlot = `CBADC_CAL_ACV_BASE;
			else if (fn == `CBADC_FN_OHM)
				calSlot = `CBADC_CAL_OHM_BASE + {2'b00, rg};
			else if (fn == `CBADC_FN_DCA)
				calSlot = `CBADC_CAL_DCV_BASE;
			else
				calSlot = `CBADC_CAL_DCV_BASE + {2'b00, rg};
		end
	endfunction

	reg [2:0] state_r;
	reg [15:0] settleCnt_r;
	reg [31:0] balCnt_r;
	reg [CW-1:0] balCount_r;
	reg [SW-1:0] slopeCount_r;
	reg [7:0] pulseCnt_r;
	reg tapPrev_r;
	reg [1:0] phase_r;
	reg [4:0] calIdx_r;
	reg [1:0] calPend_r;
	reg [CALW-1:0] calMem [0:`CBADC_CAL_WORDS-1];
	reg [2:0] dispStep_r;
	reg strobePrev_r;
	reg [12:0] addrHold_r;

	wire tap = chain[`CBADC_TAP_BIT];
	wire tapRise = tap & ~tapPrev_r;
	wire isOhms = (funcSel == `CBADC_FN_OHM);
	// Ohms needs four inputs, others three
	wire [1:0] lastPhase = isOhms ? 2'd3 : 2'd2;

	// Phase order: signal, zero, reference, then ohms reference
	function [1:0] phaseMux;
		input [1:0] ph;
		begin
			if (ph == 2'd0)
				phaseMux = `CBADC_MUX_SIG;
			else if (ph == 2'd1)
				phaseMux = `CBADC_MUX_ZERO;
			else if (ph == 2'd2)
				phaseMux = `CBADC_MUX_REF;
			else
				phaseMux = `CBADC_MUX_OHMS;
		end
	endfunction

	always @(posedge ref_clk) begin
		if (reset) begin
			state_r <= S_CAL;
			settleCnt_r <= 16'h0000;
			balCnt_r <= 32'h0000_0000;
			balCount_r <= {CW{1'b0}};
			slopeCount_r <= {SW{1'b0}};
			pulseCnt_r <= 8'h00;
			tapPrev_r <= 1'b0;
			phase_r <= 2'h0;
			calIdx_r <= 5'h00;
			calPend_r <= 2'b00;
			muxSel <= `CBADC_MUX_ZERO;
			inputEnable <= 1'b0;
			feedbackPulse <= 1'b0;
			integratorSwitch <= 1'b1;
			ohmsOffsetSwitch <= 1'b0;
			acPreampGain5 <= 1'b0;
			ohmsSenseX10 <= 1'b0;
			batteryLow <= 1'b0;
			result <= {(CW+SW){1'b0}};
			resultInput <= 2'h0;
			resultValid <= 1'b0;
			cycleDone <= 1'b0;
			calConstant <= {CALW{1'b0}};
			calReady <= 1'b0;
			calAddr <= 5'h00;
		end else if (clkEn) begin
			resultValid <= 1'b0;
			cycleDone <= 1'b0;
			tapPrev_r <= tap;
			batteryLow <= lowBattery;
			ohmsOffsetSwitch <= isOhms;
			acPreampGain5 <= (funcSel == `CBADC_FN_ACV) && (range == `CBADC_RANGE_LOW);
			ohmsSenseX10 <= isOhms && (range == `CBADC_RANGE_LOW);
			if (calReady)
				calConstant <= calMem[calSlot(funcSel, range)];
			case (state_r)
				S_CAL: begin
					// Address is registered and data follows a cycle later, so write two edges on
					calAddr <= calIdx_r;
					calPend_r <= {calPend_r[0], 1'b1};
					if (calPend_r[1])
						calMem[calIdx_r - 5'h02] <= calData;
					if (calIdx_r == `CBADC_CAL_WORDS + 1) begin
						calReady <= 1'b1;
						state_r <= S_IDLE;
					end else begin
						calIdx_r <= calIdx_r + 5'h01;
					end
				end
				S_IDLE: begin
					inputEnable <= 1'b0;
					integratorSwitch <= 1'b1;
					if (start && calReady) begin
						phase_r <= 2'h0;
						muxSel <= phaseMux(2'h0);
						settleCnt_r <= 16'h0000;
						state_r <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					inputEnable <= 1'b0;
					if (busTick) begin
						settleCnt_r <= settleCnt_r + 16'h0001;
						if (settleCnt_r + 16'h0001 >= settleCycles) begin
							inputEnable <= 1'b1;
							balCnt_r <= 32'h0000_0000;
							balCount_r <= {CW{1'b0}};
							slopeCount_r <= {SW{1'b0}};
							pulseCnt_r <= 8'h00;
							state_r <= S_BAL;
						end
					end
				end
				S_BAL: begin
					if (tapRise && !feedbackPulse) begin
						feedbackPulse <= 1'b1;
						pulseCnt_r <= balanceComparator ? `CBADC_PULSE_LONG : `CBADC_PULSE_SHORT;
					end else if (feedbackPulse && busTick) begin
						balCount_r <= balCount_r + {{(CW-1){1'b0}}, 1'b1};
						pulseCnt_r <= pulseCnt_r - 8'h01;
						if (pulseCnt_r == 8'h01)
							feedbackPulse <= 1'b0;
					end
					if (busTick) begin
						balCnt_r <= balCnt_r + 32'h0000_0001;
						if (balCnt_r + 32'h0000_0001 >= BAL_CYCLES) begin
							feedbackPulse <= 1'b0;
							integratorSwitch <= 1'b0;
							state_r <= S_SLOPE;
						end
					end
				end
				S_SLOPE: begin
					if (!slopeComparator) begin
						result <= {balCount_r, slopeCount_r};
						resultInput <= muxSel;
						resultValid <= 1'b1;
						inputEnable <= 1'b0;
						integratorSwitch <= 1'b1;
						state_r <= S_NEXT;
					end else if (busTick) begin
						slopeCount_r <= slopeCount_r + {{(SW-1){1'b0}}, 1'b1};
					end
				end
				S_NEXT: begin
					if (phase_r == lastPhase) begin
						cycleDone <= 1'b1;
						muxSel <= `CBADC_MUX_ZERO;
						state_r <= S_IDLE;
					end else begin
						phase_r <= phase_r + 2'h1;
						muxSel <= phaseMux(phase_r + 2'h1);
						settleCnt_r <= 16'h0000;
						state_r <= S_SETTLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Address latch and display setup
	always @(posedge ref_clk) begin
		if (reset) begin
			strobePrev_r <= 1'b0;
			addrHold_r <= 13'h0000;
			progAddr <= 13'h0000;
			dispStep_r <= 3'h0;
			displayCtrl <= 4'h0;
		end else if (clkEn) begin
			strobePrev_r <= addrStrobe;
			if (addrStrobe && !strobePrev_r)
				addrHold_r <= busAddr;
			if (dataStrobe)
				progAddr <= addrHold_r;
			// Sequenced words on the four control lines, then idle
			if (dispStep_r < `CBADC_DISP_STEPS) begin
				dispStep_r <= dispStep_r + 3'h1;
				displayCtrl <= (dispStep_r == 3'h0) ? `CBADC_DISP_CFG : {1'b1, dispStep_r};
			end else begin
				displayCtrl <= 4'h0;
			end
		end
	end
endmodule // cbadc_sequencer
`default_nettype wire

// file: bench/cbadc_seq_asserts.sv
// Checker for the converter sequencer ports
`timescale 1ns/10ps
`default_nettype none
module cbadc_seq_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Watched ports
	input wire logic [2:0] funcSel,
	input wire logic [2:0] range,
	input wire logic [15:0] settleCycles,
	input wire logic slopeComparator,
	input wire logic lowBattery,
	input wire logic batteryLow,
	input wire logic [1:0] muxSel,
	input wire logic inputEnable,
	input wire logic feedbackPulse,
	input wire logic integratorSwitch,
	input wire logic ohmsOffsetSwitch,
	input wire logic acPreampGain5,
	input wire logic ohmsSenseX10,
	input wire logic [1:0] resultInput,
	input wire logic resultValid,
	input wire logic [3:0] displayCtrl
);
	// Low time before each enable; saturates so long idle spells cannot wrap
	logic [19:0] lowCnt;
	always @(posedge ref_clk) begin
		if (reset || inputEnable)
			lowCnt <= 20'h0_0000;
		else if (lowCnt != 20'hF_FFFF)
			lowCnt <= lowCnt + 20'h0_0001;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_OFFSET: assert property (1 |=> ohmsOffsetSwitch == ($past(funcSel) == 3'h2))
		else $error("offset switch wrong");
	AST_GAIN: assert property (1 |=> acPreampGain5 == ($past(funcSel) == 3'h1 && $past(range) == 3'h0))
		else $error("preamp gain wrong");
	AST_X10: assert property (1 |=> ohmsSenseX10 == ($past(funcSel) == 3'h2 && $past(range) == 3'h0))
		else $error("sense scaling wrong");
	// First tick may come one clock after the mux change, two after enable falls, hence the slack of three
	AST_SETTLE: assert property ($rose(inputEnable) |->
		lowCnt + 20'h0_0003 >= 20'h0_0005 * {4'h0, settleCycles} && $stable(muxSel))
		else $error("settle too short");
	AST_BATT: assert property (1 |=> batteryLow == $past(lowBattery))
		else $error("battery flag wrong");
	AST_PULSE: assert property (feedbackPulse |-> integratorSwitch)
		else $error("feedback outside balance");
	AST_SLOPE: assert property (resultValid |-> !$past(slopeComparator))
		else $error("result before slope end");
	AST_VALID: assert property (resultValid |=> !resultValid)
		else $error("valid longer than one cycle");
	AST_DISP: assert property ($fell(reset) |-> ##1 displayCtrl == 4'h3 ##1 displayCtrl == 4'h9
		##1 displayCtrl == 4'hA ##1 displayCtrl == 4'hB ##1 displayCtrl == 4'h0)
		else $error("display setup wrong");
	cover property (resultValid && resultInput == 2'h3);
	cover property ($rose(feedbackPulse));
	cover property ($fell(integratorSwitch));
endmodule // cbadc_seq_asserts
bind cbadc_sequencer cbadc_seq_asserts cbadc_seq_asserts_inst (.ref_clk(ref_clk), .reset(reset),
	.funcSel(funcSel), .range(range), .settleCycles(settleCycles), .slopeComparator(slopeComparator),
	.lowBattery(lowBattery), .batteryLow(batteryLow), .muxSel(muxSel),
	.inputEnable(inputEnable), .feedbackPulse(feedbackPulse), .integratorSwitch(integratorSwitch),
	.ohmsOffsetSwitch(ohmsOffsetSwitch), .acPreampGain5(acPreampGain5), .ohmsSenseX10(ohmsSenseX10),
	.resultInput(resultInput), .resultValid(resultValid), .displayCtrl(displayCtrl));
`default_nettype wire

// file: bench/cbadc_front_model.sv
// Analog front end and calibration store model
`timescale 1ns/10ps
`default_nettype none
module cbadc_front_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Bench controls
	input wire logic [3:0] level,
	input wire logic [7:0] slopeLen,
	// Sequencer side
	input wire logic inputEnable,
	input wire logic feedbackPulse,
	input wire logic integratorSwitch,
	input wire logic [4:0] calAddr,
	output logic balanceComparator,
	output logic slopeComparator,
	output logic [15:0] calData
);
	logic signed [15:0] integ;
	logic [7:0] slopeCnt;
	always @(posedge ref_clk) begin
		if (reset || !inputEnable) begin
			integ <= 16'sh0000;
		end else if (integratorSwitch) begin
			// Feedback current pulls the ramp back
			integ <= integ + $signed({12'h000, level}) - (feedbackPulse ? 16'sh0006 : 16'sh0000);
		end
		slopeCnt <= integratorSwitch ? 8'h00 : slopeCnt + {7'h00, slopeCnt < slopeLen};
		calData <= 16'hC000 | {11'h000, calAddr};
	end
	assign balanceComparator = integ > 16'sh0000;
	assign slopeComparator = !integratorSwitch && slopeCnt < slopeLen;
endmodule // cbadc_front_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_top;
	logic ref_clk, reset, start, lowBattery, addrStrobe, dataStrobe, balanceComparator, slopeComparator;
	logic inputEnable, feedbackPulse, integratorSwitch, resultValid, cycleDone, calReady, clkEn, batteryLow;
	logic [1:0] batHist;
	localparam int BAL_TICKS = 50;
	logic [2:0] fnSel, range;
	logic [15:0] settleCycles, calData, calConstant;
	logic [12:0] busAddr, progAddr;
	logic [3:0] level;
	logic [7:0] slopeLen;
	logic [4:0] calAddr;
	logic [39:0] result;
	logic [1:0] resultInput, ph;
	logic [2:0] fTab [7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
	logic [2:0] rTab [7] = '{3'h2, 3'h0, 3'h4, 3'h0, 3'h3, 3'h1, 3'h2};
	integer err_total = 0, total_checks = 0, seed = 32'h7602, i, k, a, balLen;
	cbadc_sequencer #(.BAL_CYCLES(BAL_TICKS)) cbadc_sequencer_inst (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
		.start(start), .funcSel(fnSel), .range(range), .settleCycles(settleCycles),
		.balanceComparator(balanceComparator), .slopeComparator(slopeComparator), .lowBattery(lowBattery),
		.muxSel(), .inputEnable(inputEnable), .feedbackPulse(feedbackPulse), .integratorSwitch(integratorSwitch),
		.ohmsOffsetSwitch(), .acPreampGain5(), .ohmsSenseX10(), .batteryLow(batteryLow), .result(result),
		.resultInput(resultInput), .resultValid(resultValid), .cycleDone(cycleDone), .calConstant(calConstant),
		.calReady(calReady), .calAddr(calAddr), .calData(calData), .addrStrobe(addrStrobe),
		.dataStrobe(dataStrobe), .busAddr(busAddr), .progAddr(progAddr), .displayCtrl());
	cbadc_front_model cbadc_front_model_inst (.ref_clk(ref_clk), .reset(reset), .level(level),
		.slopeLen(slopeLen), .inputEnable(inputEnable), .feedbackPulse(feedbackPulse),
		.integratorSwitch(integratorSwitch), .calAddr(calAddr), .balanceComparator(balanceComparator),
		.slopeComparator(slopeComparator), .calData(calData));
	function automatic logic [15:0] exp_cal(input logic [2:0] f, input logic [2:0] r);
		case (f)
			3'h0: return 16'hC000 | r;
			3'h1: return 16'hC008 | ((r == 3'h4) ? 3'h1 : r);
			3'h2: return 16'hC010 | r;
			3'h3: return 16'hC000;
			default: return 16'hC008;
		endcase
	endfunction
	task automatic close_out;
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic run_cycle(input logic [2:0] f, input logic [2:0] r);
		fnSel <= f;
		range <= r;
		settleCycles <= 16'h0002 + ($random(seed) & 3);
		slopeLen <= 8'h0A + ($random(seed) & 31);
		level <= 4'h1 + ($random(seed) & 3);
		repeat (40) @(posedge ref_clk);
		`CHK(calConstant, exp_cal(f, r))
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		ph = 2'h0;
		balLen = 0;
		batHist = {2{lowBattery}};
		for (k = 0; k < 8000 && cycleDone !== 1'b1; k++) begin
			@(posedge ref_clk);
			`CHK(batteryLow, batHist[1])
			a = $random(seed);
			lowBattery <= a[0];
			batHist = {batHist[0], a[0]};
			if (inputEnable === 1'b1 && integratorSwitch === 1'b1)
				balLen++;
			if (resultValid === 1'b1) begin
				`CHK(resultInput, ph)
				`CHK(result[39:16] != 24'h0, 1'b1)
				`CHK(balLen, BAL_TICKS * 5)
				`CHK(result[15:0] >= slopeLen / 5 && result[15:0] <= slopeLen / 5 + 1, 1'b1)
				balLen = 0;
				ph++;
			end
		end
		`CHK(ph, (f == 3'h2) ? 2'h0 : 2'h3)
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		close_out;
	end
	initial begin
		{clkEn, reset, start, lowBattery, addrStrobe, dataStrobe} = 6'h30;
		{fnSel, range, settleCycles, busAddr, level, slopeLen} = 0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		for (k = 0; k < 200 && calReady !== 1'b1; k++) @(posedge ref_clk);
		`CHK(calReady, 1'b1)
		for (i = 0; i < 3; i++) begin
			a = $random(seed);
			busAddr <= a[12:0];
			addrStrobe <= 1'b1;
			repeat (2) @(posedge ref_clk);
			addrStrobe <= 1'b0;
			busAddr <= ~a[12:0];
			dataStrobe <= 1'b1;
			repeat (3) @(posedge ref_clk);
			`CHK(progAddr, a[12:0])
			dataStrobe <= 1'b0;
		end
		// Frozen block must ignore a full strobe pair
		@(posedge ref_clk);
		clkEn <= 1'b0;
		busAddr <= ~a[12:0];
		addrStrobe <= 1'b1;
		dataStrobe <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK(progAddr, a[12:0])
		{clkEn, addrStrobe, dataStrobe} <= 3'b100;
		for (i = 0; i < 7; i++) run_cycle(fTab[i], rTab[i]);
		close_out;
	end
endmodule // tb_top
`default_nettype wire
